// ===== uopc_defines.vh
// constants for the usb line and vbus control block
// assumes inclusion by bare name from the design files
`ifndef UOPC_DEFINES_VH
`define UOPC_DEFINES_VH
`define UOPC_ADDR_W 8
`define UOPC_CTRL_ADDR 8'h00
`define UOPC_CTRL_RESET 8'h00
`define UOPC_BIT_DP_PULLUP 7
`define UOPC_BIT_DM_PULLUP 6
`define UOPC_BIT_DP_PULLDOWN 5
`define UOPC_BIT_DM_PULLDOWN 4
`define UOPC_BIT_VBUS_ON 3
`define UOPC_BIT_SW_SELECT 2
`define UOPC_BIT_VBUS_CHARGE 1
`define UOPC_BIT_VBUS_DISCHARGE 0
`define UOPC_HTRANS_NONSEQ 2'h2
`define UOPC_HSIZE_WORD 3'h2
`define UOPC_WORD_ZERO 32'h00000000
`define UOPC_CTRL_W 8
`define UOPC_PULL_W 4
`endif

// ===== uopc_peer.sv
// usb engine pull request source facing the pad block
// assumes the bench picks the pattern; it changes after a clock edge
`timescale 1ns/100ps
module uopc_peer (
    input wire mclk,
    input wire [3:0] req,
    output reg [3:0] engine_pulls
);
initial engine_pulls = 4'h0;
always @(posedge mclk) engine_pulls <= req;
endmodule

// ===== uopc_pull_mux.v
// chooses software or engine source for the four line pulls
// assumes both sources are already in the mclk domain
`timescale 1ns/100ps
module uopc_pull_mux (
    // select
    input wire software_pull_select,
    // sources, order dp_up dm_up dp_down dm_down
    input wire [3:0] sw_pulls,
    input wire [3:0] hw_pulls,
    // result
    output wire [3:0] pulls
);
    assign pulls = software_pull_select ? sw_pulls : hw_pulls;
endmodule

// ===== uopc_sync.v
// two-flop synchroniser for pin-side levels
// assumes inputs come from outside the mclk domain
`timescale 1ns/100ps
module uopc_sync #(
    parameter WIDTH = 4
) (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // levels
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// ===== uopc_top.v
// usb line and vbus control register with ahb-lite slave
// assumes a single ahb-lite master, word transfers, hready from hreadyout
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "uopc_defines.vh"
module uopc_top (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // ahb-lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // engine pull requests, order dp_up dm_up dp_down dm_down
    input wire [3:0] engine_pulls,
    // pads
    output reg dplus_pullup_enable,
    output reg dminus_pullup_enable,
    output reg dplus_pulldown_enable,
    output reg dminus_pulldown_enable,
    output reg vbus_supply_on,
    output reg vbus_charge_enable,
    output reg vbus_discharge_enable
);
    reg [`UOPC_CTRL_W-1:0] usb_otg_line_and_vbus_control;
    reg wr_pend;
    reg rd_pend;
    wire addr_hit;
    wire take;
    wire [3:0] engine_sync;
    wire [3:0] sw_pulls;
    wire [3:0] pulls;

    // engine pulls may come from another clock, so synchronise them
    uopc_sync #(
        .WIDTH(`UOPC_PULL_W)
    ) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .din(engine_pulls),
        .dout(engine_sync)
    );

    assign sw_pulls = {usb_otg_line_and_vbus_control[`UOPC_BIT_DP_PULLUP],
        usb_otg_line_and_vbus_control[`UOPC_BIT_DM_PULLUP],
        usb_otg_line_and_vbus_control[`UOPC_BIT_DP_PULLDOWN],
        usb_otg_line_and_vbus_control[`UOPC_BIT_DM_PULLDOWN]};

    uopc_pull_mux u_mux (
        .software_pull_select(usb_otg_line_and_vbus_control[`UOPC_BIT_SW_SELECT]),
        .sw_pulls(sw_pulls),
        .hw_pulls(engine_sync),
        .pulls(pulls)
    );

    assign take = hsel && hready && (htrans == `UOPC_HTRANS_NONSEQ);
    assign addr_hit = (haddr[`UOPC_ADDR_W-1:0] == `UOPC_CTRL_ADDR);

    // zero wait states; unmapped addresses read zero and drop writes
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= take && hwrite && addr_hit;
            rd_pend <= take && !hwrite && addr_hit;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            usb_otg_line_and_vbus_control <= `UOPC_CTRL_RESET;
        end else if (wr_pend) begin
            // upper bits dropped, pull bits stored whatever the select
            usb_otg_line_and_vbus_control <= hwdata[`UOPC_CTRL_W-1:0];
        end
    end

    // read data is presented in the data phase, computed from the stored bits
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= `UOPC_WORD_ZERO;
        end else if (take && !hwrite && addr_hit) begin
            hrdata <= {24'h000000, usb_otg_line_and_vbus_control};
        end else begin
            hrdata <= `UOPC_WORD_ZERO;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dplus_pullup_enable <= 1'b0;
            dminus_pullup_enable <= 1'b0;
            dplus_pulldown_enable <= 1'b0;
            dminus_pulldown_enable <= 1'b0;
            vbus_supply_on <= 1'b0;
            vbus_charge_enable <= 1'b0;
            vbus_discharge_enable <= 1'b0;
        end else begin
            dplus_pullup_enable <= pulls[3];
            dminus_pullup_enable <= pulls[2];
            dplus_pulldown_enable <= pulls[1];
            dminus_pulldown_enable <= pulls[0];
            vbus_supply_on <= usb_otg_line_and_vbus_control[`UOPC_BIT_VBUS_ON];
            vbus_charge_enable <= usb_otg_line_and_vbus_control[`UOPC_BIT_VBUS_CHARGE];
            vbus_discharge_enable <=
                usb_otg_line_and_vbus_control[`UOPC_BIT_VBUS_DISCHARGE];
        end
    end
endmodule

// ===== uopc_top_assertions.sv
// port checks for the usb line and vbus control block
// assumes zero-wait word writes at byte 0; the write lands at the end of its data phase
// and the pads show it one edge later, so they are sampled two edges after the data phase
`timescale 1ns/100ps
module uopc_chk (
    input wire mclk, reset_n, hsel, hwrite, hready,
    input wire [1:0] htrans,
    input wire [31:0] haddr, hwdata, hrdata,
    input wire dplus_pullup_enable, dminus_pullup_enable, dplus_pulldown_enable,
    input wire dminus_pulldown_enable, vbus_supply_on, vbus_charge_enable, vbus_discharge_enable
);
reg wr_ph;
always @(posedge mclk or negedge reset_n)
    if (!reset_n) wr_ph <= 1'b0;
    else if (hready) wr_ph <= hsel && hwrite && htrans == 2'h2 && haddr[7:0] == 8'h00;
default clocking @(posedge mclk); endclocking
default disable iff (!reset_n);
// pull pads are only checked on writes that give software the pulls
sequence sw_wr; wr_ph && hwdata[2]; endsequence
upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("high bits");
dp_up_a: assert property (sw_wr |-> ##2 dplus_pullup_enable == $past(hwdata[7], 2))
    else $error("dp up");
dm_up_a: assert property (sw_wr |-> ##2 dminus_pullup_enable == $past(hwdata[6], 2))
    else $error("dm up");
dp_down_a: assert property (sw_wr |-> ##2 dplus_pulldown_enable == $past(hwdata[5], 2))
    else $error("dp down");
dm_down_a: assert property (sw_wr |-> ##2 dminus_pulldown_enable == $past(hwdata[4], 2))
    else $error("dm down");
vbus_on_a: assert property (wr_ph |-> ##2 vbus_supply_on == $past(hwdata[3], 2))
    else $error("vbus on");
vbus_chg_a: assert property (wr_ph |-> ##2 vbus_charge_enable == $past(hwdata[1], 2))
    else $error("vbus chg");
vbus_dis_a: assert property (wr_ph |-> ##2 vbus_discharge_enable == $past(hwdata[0], 2))
    else $error("vbus dis");
endmodule
bind uopc_top uopc_chk i_chk (.*);

// ===== usb_otg_pad_control_tb_top.sv
// bench for the usb line and vbus control block
// assumes uopc_top, uopc_peer and the checker are compiled before it
`timescale 1ns/100ps
module usb_otg_pad_control_tb_top;
reg mclk = 0, reset_n = 0, hsel = 0, hwrite = 0;
reg [1:0] htrans = 0;
reg [31:0] haddr = 0, hwdata = 0, r;
reg [3:0] req = 0;
reg [7:0] v;
wire [31:0] hrdata;
wire hreadyout, hresp;
wire [3:0] engine_pulls;
wire [6:0] pads;
int err_count = 0, num_checks = 0;
always #20 mclk = ~mclk;
uopc_peer i_peer (.mclk(mclk), .req(req), .engine_pulls(engine_pulls));
uopc_top i_dut (.*, .hsize(3'h2), .hready(hreadyout), .dplus_pullup_enable(pads[6]),
    .dminus_pullup_enable(pads[5]), .dplus_pulldown_enable(pads[4]),
    .dminus_pulldown_enable(pads[3]), .vbus_supply_on(pads[2]),
    .vbus_charge_enable(pads[1]), .vbus_discharge_enable(pads[0]));
task print_verdict;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task chk(input [31:0] seen, input [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
        err_count++;
        $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
endtask
// bounded wait for hready at the next edges
task wt;
    int n;
    n = 0;
    @(posedge mclk);
    while (hreadyout !== 1'b1) begin
        n++;
        if (n > 20) begin
            err_count++;
            print_verdict;
        end
        @(posedge mclk);
    end
endtask
task xfer(input [31:0] a, input w, input [31:0] d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wt;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    r = hrdata;
endtask
initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk);
    xfer(0, 0, 0);
    chk(r, 0);
    chk(pads, 0);
    chk(hresp, 0);
    chk(hreadyout, 1);
    req <= 4'hA;
    xfer(0, 1, 32'hFFFFFFF3);
    repeat (5) @(posedge mclk);
    chk(pads, 7'h53);
    xfer(0, 0, 0);
    chk(r, 32'hF3);
    $display("engine test done");
    for (int i = 0; i < 8; i++) begin
        v = 8'h04 | (8'h01 << i);
        xfer(0, 1, {24'hFFFFFF, v});
        xfer(0, 0, 0);
        chk(r, {24'h0, v});
        chk(pads, {v[7:3], v[1:0]});
    end
    $display("software test done");
    xfer(32'h10, 1, 32'hFF);
    xfer(32'h10, 0, 0);
    chk(r, 0);
    xfer(0, 0, 0);
    chk(r, 32'h84);
    reset_n <= 0;
    @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk);
    xfer(0, 0, 0);
    chk(r, 0);
    $display("reset test done");
    print_verdict;
end
endmodule
